// File: hdl/bridge_ctrl.sv
// Serial slave port, register file and operating modes of the bridge driver

// Summary of operation
// - Frames are 16-bit words, MSB first, 16 clocks with select low.
// - Incoming data sampled on serial clock falling edges.
// - Outgoing data changes on serial clock rising edges.
// - Bits beyond 16 are passed out on the data output for chaining.
// - Zero or non-multiple-of-16 clock counts discard frame, set framing flag.
// - Reply is register selected by previous frame, captured at select fall.
// - First frame after wake returns the status register.
// - Read frames ignore payload and change no register.
// - Slave only, fixed clock mode; master drives clock and select.
// - Sleep disables everything including the serial port.
// - Standby runs all logic and serial port, outputs high impedance.
// - Normal mode moves to fault mode on any detected fault; code counts only status faults enabled in mask_r, plus pump low.
// - Fault mode forces outputs off and latches fault flag low.
// - Wake input rise wakes device; supply good starts power-up.
// - Power-up flag held 1 to 2 us, released once pump good, faults clear.
// - Fault flag high no later than 1 ms after wake.
// - Wake input low turns outputs off and drives fault flag low.
// - Flag release allowed only after 8 to 11 us power-down delay.
// - After delay, release needs inhibit low; held until supplies off.
// - Thermal warning flagged; above it current limit is halved.
// - Outputs governed by wake, inhibit, parallel and soft control bits.
// - Bit 15 write/read; bits 14:13 pick ident, status, mask, config.
// - A write to select code 00 is a framing error.
// - Writing 1 clears a latched fault unless still present.
module bridge_ctrl (
	// Clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               reset_n,
	// Serial port
	input  wire logic                               serial_clk,
	input  wire logic                               select_n,
	input  wire logic                               serial_in,
	output logic                                    serial_out,
	output logic                                    serial_out_en,
	// Parallel control pins
	input  wire logic                               wake_input,
	input  wire logic                               output_inhibit_input,
	input  wire logic                               bridge_control_a,
	input  wire logic                               bridge_control_b,
	// Analog monitors
	input  wire logic                               supply_good,
	input  wire logic                               pump_low_threshold,
	input  wire logic [bridge_pkg::FAULT_BITS-1:0]  fault_live,
	input  wire logic                               thermal_warning_level,
	input  wire logic                               supplies_off,
	// Outputs
	output logic                                    fault_flag_n,
	output logic                                    bridge_output_a,
	output logic                                    bridge_output_b,
	output logic                                    bridge_output_en,
	output logic                                    current_limit_half,
	output logic                                    regulator_on,
	output logic                                    standby
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [7:0] sync_q;

	sync2 #(.WIDTH(8)) u_sync (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.async_in ({serial_clk, select_n, serial_in, wake_input, output_inhibit_input,
			bridge_control_a, bridge_control_b, supplies_off}),
		.sync_out (sync_q)
	);

	logic sclk_s, sel_n_s, sdi_s, wake_s, inhibit_s, ctl_a_s, ctl_b_s, off_s;
	assign {sclk_s, sel_n_s, sdi_s, wake_s, inhibit_s, ctl_a_s, ctl_b_s, off_s} = sync_q;

	// ----------------------------------------------------------------
	// Edge history
	// ----------------------------------------------------------------
	logic sclk_d_r, sel_d_r, wake_d_r;
	logic sclk_d_nxt, sel_d_nxt, wake_d_nxt;

	always_comb begin
		sclk_d_nxt = sclk_s;
		sel_d_nxt  = sel_n_s;
		wake_d_nxt = wake_s;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d_r <= 1'b0;
			sel_d_r  <= 1'b1;
			wake_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
			sel_d_r  <= sel_d_nxt;
			wake_d_r <= wake_d_nxt;
		end
	end

	logic sclk_rise, sclk_fall, sel_fall, sel_rise, wake_rise;
	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign sclk_fall = ~sclk_s & sclk_d_r;
	assign sel_fall  = ~sel_n_s & sel_d_r;
	assign sel_rise  = sel_n_s & ~sel_d_r;
	assign wake_rise = wake_s & ~wake_d_r;

	// ----------------------------------------------------------------
	// Operating mode sequencer
	// ----------------------------------------------------------------
	bridge_pkg::mode_t                mode_r, mode_nxt;
	logic [bridge_pkg::TIMER_W-1:0]   timer_r, timer_nxt;
	logic                             flag_n_r, flag_n_nxt;
	logic                             any_fault;
	logic [15:0]                      status_r;
	logic [15:0]                      mask_r;
	logic [15:0]                      cfg_r;

	// Pump undervoltage and masked faults count toward the flag
	assign any_fault = |(status_r[bridge_pkg::FAULT_BITS-1:0]
		& mask_r[bridge_pkg::FAULT_BITS-1:0]);

	always_comb begin
		mode_nxt   = mode_r;
		timer_nxt  = timer_r;
		flag_n_nxt = flag_n_r;
		case (mode_r)
			bridge_pkg::MODE_SLEEP: begin
				// Supplies are off, so the flag stays released
				flag_n_nxt = 1'b1;
				timer_nxt  = '0;
				if (wake_rise && supply_good) begin
					mode_nxt = bridge_pkg::MODE_POWERUP;
				end
			end
			bridge_pkg::MODE_POWERUP: begin
				flag_n_nxt = 1'b0;
				if (timer_r != bridge_pkg::TIMER_W'(bridge_pkg::TURN_ON_MAX_CYC)) begin
					timer_nxt = timer_r + 1'b1;
				end
				if (!wake_s) begin
					mode_nxt  = bridge_pkg::MODE_PDDELAY;
					timer_nxt = '0;
				end else if (timer_r >= bridge_pkg::TIMER_W'(bridge_pkg::POWERUP_FLAG_CYC - 1)
						&& !pump_low_threshold && !any_fault) begin
					mode_nxt = bridge_pkg::MODE_NORMAL;
				end else if (timer_r == bridge_pkg::TIMER_W'(bridge_pkg::TURN_ON_MAX_CYC)) begin
					mode_nxt = bridge_pkg::MODE_FAULT;
				end
			end
			bridge_pkg::MODE_NORMAL: begin
				flag_n_nxt = 1'b1;
				if (!wake_s) begin
					mode_nxt   = bridge_pkg::MODE_PDDELAY;
					timer_nxt  = '0;
					flag_n_nxt = 1'b0;
				end else if (any_fault || pump_low_threshold) begin
					mode_nxt   = bridge_pkg::MODE_FAULT;
					flag_n_nxt = 1'b0;
				end
			end
			bridge_pkg::MODE_FAULT: begin
				flag_n_nxt = 1'b0;
				if (!wake_s) begin
					mode_nxt  = bridge_pkg::MODE_PDDELAY;
					timer_nxt = '0;
				end else if (!any_fault && !pump_low_threshold) begin
					mode_nxt   = bridge_pkg::MODE_NORMAL;
					flag_n_nxt = 1'b1;
				end
			end
			bridge_pkg::MODE_PDDELAY: begin
				flag_n_nxt = 1'b0;
				timer_nxt  = timer_r + 1'b1;
				if (wake_rise && supply_good) begin
					mode_nxt  = bridge_pkg::MODE_POWERUP;
					timer_nxt = '0;
				end else if (timer_r == bridge_pkg::TIMER_W'(bridge_pkg::POWERDOWN_DELAY_CYC - 1)) begin
					mode_nxt = bridge_pkg::MODE_PDWAIT;
				end
			end
			bridge_pkg::MODE_PDWAIT: begin
				flag_n_nxt = 1'b0;
				if (wake_rise && supply_good) begin
					mode_nxt  = bridge_pkg::MODE_POWERUP;
					timer_nxt = '0;
				end else if (off_s && !inhibit_s) begin
					mode_nxt   = bridge_pkg::MODE_SLEEP;
					flag_n_nxt = 1'b1;
				end
			end
			default: begin
				mode_nxt   = bridge_pkg::MODE_SLEEP;
				flag_n_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r   <= bridge_pkg::MODE_SLEEP;
			timer_r  <= '0;
			flag_n_r <= 1'b0;
		end else begin
			mode_r   <= mode_nxt;
			timer_r  <= timer_nxt;
			flag_n_r <= flag_n_nxt;
		end
	end

	// Serial port runs whenever regulators are up
	logic port_alive;
	assign port_alive = (mode_r != bridge_pkg::MODE_SLEEP);

	// ----------------------------------------------------------------
	// Serial shifter and frame check
	// ----------------------------------------------------------------
	logic [15:0]                    rx_r, rx_nxt;
	logic [15:0]                    tx_r, tx_nxt;
	logic [bridge_pkg::COUNT_W-1:0] cnt_r, cnt_nxt;
	logic                           sdo_r, sdo_nxt;
	logic                           sdo_en_r, sdo_en_nxt;
	logic                           overflow_r, overflow_nxt;
	logic [1:0]                     sel_prev_r, sel_prev_nxt;
	logic                           first_r, first_nxt;
	logic                           frame_ok, frame_bad, frame_wr;
	logic [1:0]                     frame_sel;
	logic [15:0]                    reply_word;

	// Overflow flag keeps counts past 255 from aliasing to a multiple of 16
	assign frame_ok  = sel_rise && port_alive && (cnt_r != '0) && (cnt_r[3:0] == 4'h0)
		&& !overflow_r;
	assign frame_sel = rx_r[bridge_pkg::SEL_HI:bridge_pkg::SEL_LO];
	assign frame_wr  = rx_r[bridge_pkg::WRITE_BIT];
	assign frame_bad = sel_rise && port_alive
		&& (!frame_ok || (frame_wr && frame_sel == bridge_pkg::SEL_IDENT));

	always_comb begin
		case (first_r ? bridge_pkg::SEL_STATUS : sel_prev_r)
			bridge_pkg::SEL_IDENT:  reply_word = bridge_pkg::IDENT_VALUE;
			bridge_pkg::SEL_STATUS: reply_word = {4'h2, status_r[11:0]};
			bridge_pkg::SEL_MASK:   reply_word = {3'h2, mask_r[12:0]};
			default:                reply_word = {3'h3, cfg_r[12:0]};
		endcase
	end

	always_comb begin
		rx_nxt       = rx_r;
		tx_nxt       = tx_r;
		cnt_nxt      = cnt_r;
		sdo_nxt      = sdo_r;
		sdo_en_nxt   = sdo_en_r;
		overflow_nxt = overflow_r;
		sel_prev_nxt = sel_prev_r;
		first_nxt    = first_r;
		if (wake_rise) begin
			first_nxt = 1'b1;
		end
		if (!port_alive || sel_n_s) begin
			sdo_en_nxt = 1'b0;
		end
		if (port_alive && sel_fall) begin
			tx_nxt       = {reply_word[14:0], 1'b0};
			sdo_nxt      = reply_word[15];
			sdo_en_nxt   = 1'b1;
			cnt_nxt      = '0;
			overflow_nxt = 1'b0;
		end else if (port_alive && !sel_n_s) begin
			if (sclk_fall) begin
				rx_nxt  = {rx_r[14:0], sdi_s};
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == '1) begin
					overflow_nxt = 1'b1;
				end
			end
			if (sclk_rise && cnt_r != '0) begin
				// After the first word the received bits follow for chaining
				sdo_nxt = (cnt_r > bridge_pkg::COUNT_W'(bridge_pkg::WORD_BITS - 1))
					? rx_r[15] : tx_r[15];
				tx_nxt  = {tx_r[14:0], 1'b0};
			end
		end
		if (frame_ok && !frame_bad) begin
			sel_prev_nxt = frame_sel;
			first_nxt    = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_r       <= '0;
			tx_r       <= '0;
			cnt_r      <= '0;
			sdo_r      <= 1'b0;
			sdo_en_r   <= 1'b0;
			overflow_r <= 1'b0;
			sel_prev_r <= bridge_pkg::SEL_STATUS;
			first_r    <= 1'b1;
		end else begin
			rx_r       <= rx_nxt;
			tx_r       <= tx_nxt;
			cnt_r      <= cnt_nxt;
			sdo_r      <= sdo_nxt;
			sdo_en_r   <= sdo_en_nxt;
			overflow_r <= overflow_nxt;
			sel_prev_r <= sel_prev_nxt;
			first_r    <= first_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [15:0] status_nxt, mask_nxt, cfg_nxt;
	logic [15:0] live_word;
	logic        do_write;

	assign live_word = {4'h0, 1'b0, fault_live[10:2], thermal_warning_level, fault_live[0]};
	assign do_write  = frame_ok && frame_wr;

	always_comb begin
		status_nxt = status_r;
		mask_nxt   = mask_r;
		cfg_nxt    = cfg_r;
		if (do_write && frame_sel == bridge_pkg::SEL_STATUS) begin
			status_nxt = status_r & ~{4'h0, rx_r[11:0]};
		end
		if (do_write && frame_sel == bridge_pkg::SEL_MASK) begin
			mask_nxt = {3'h0, rx_r[12:0]};
		end
		if (do_write && frame_sel == bridge_pkg::SEL_CONFIG) begin
			cfg_nxt = {3'h0, rx_r[12:0]};
		end
		// Setting after clearing so a live fault or new error is kept
		status_nxt = status_nxt | live_word;
		if (frame_bad) begin
			status_nxt[bridge_pkg::STAT_FRAME] = 1'b1;
		end
		status_nxt[bridge_pkg::STAT_PUMP_LO] = status_nxt[bridge_pkg::STAT_PUMP_LO]
			| (pump_low_threshold && mode_r == bridge_pkg::MODE_NORMAL);
		if (!port_alive) begin
			status_nxt = '0;
			mask_nxt   = bridge_pkg::MASK_RESET;
			cfg_nxt    = bridge_pkg::CFG_RESET;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
			mask_r   <= bridge_pkg::MASK_RESET;
			cfg_r    <= bridge_pkg::CFG_RESET;
		end else begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			cfg_r    <= cfg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Output gating
	// ----------------------------------------------------------------
	logic out_a_r, out_b_r, out_en_r, half_r, reg_on_r, standby_r;
	logic out_a_nxt, out_b_nxt, out_en_nxt, half_nxt, reg_on_nxt, standby_nxt;

	always_comb begin
		out_en_nxt  = (mode_r == bridge_pkg::MODE_NORMAL) && wake_s && !inhibit_s
			&& cfg_r[bridge_pkg::CFG_SOFT_ON];
		out_a_nxt   = out_en_nxt && (ctl_a_s ^ cfg_r[bridge_pkg::CFG_SOFT_A]);
		out_b_nxt   = out_en_nxt && (ctl_b_s ^ cfg_r[bridge_pkg::CFG_SOFT_B]);
		half_nxt    = port_alive && thermal_warning_level;
		reg_on_nxt  = port_alive;
		standby_nxt = port_alive && !out_en_nxt;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_a_r   <= 1'b0;
			out_b_r   <= 1'b0;
			out_en_r  <= 1'b0;
			half_r    <= 1'b0;
			reg_on_r  <= 1'b0;
			standby_r <= 1'b0;
		end else begin
			out_a_r   <= out_a_nxt;
			out_b_r   <= out_b_nxt;
			out_en_r  <= out_en_nxt;
			half_r    <= half_nxt;
			reg_on_r  <= reg_on_nxt;
			standby_r <= standby_nxt;
		end
	end

	assign serial_out         = sdo_r;
	assign serial_out_en      = sdo_en_r;
	assign fault_flag_n       = flag_n_r;
	assign bridge_output_a    = out_a_r;
	assign bridge_output_b    = out_b_r;
	assign bridge_output_en   = out_en_r;
	assign current_limit_half = half_r;
	assign regulator_on       = reg_on_r;
	assign standby            = standby_r;

endmodule

// File: shared/bridge_pkg.sv
// Shared constants and types for the bridge driver serial port and mode control
package bridge_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS          = 4000;
	localparam int POWERUP_FLAG_MIN_NS    = 1000;
	localparam int POWERUP_FLAG_MAX_NS    = 2000;
	localparam int POWERUP_FLAG_CYC       = (POWERUP_FLAG_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int TURN_ON_MAX_US         = 1000;
	localparam int TURN_ON_MAX_CYC        = (TURN_ON_MAX_US * 1000000) / CLK_PERIOD_PS;
	localparam int POWERDOWN_DELAY_MIN_NS = 8000;
	localparam int POWERDOWN_DELAY_MAX_NS = 11000;
	localparam int POWERDOWN_DELAY_CYC    = (POWERDOWN_DELAY_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int TIMER_W                = 18;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int WORD_BITS   = 16;
	localparam int WRITE_BIT   = 15;
	localparam int SEL_HI      = 14;
	localparam int SEL_LO      = 13;
	localparam int COUNT_W     = 8;

	localparam logic [1:0] SEL_IDENT  = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_MASK   = 2'h2;
	localparam logic [1:0] SEL_CONFIG = 2'h3;

	// ----------------------------------------------------------------
	// Register fields and reset values
	// ----------------------------------------------------------------
	localparam int STAT_FRAME   = 11;
	localparam int STAT_PUMP_LO = 10;
	localparam int STAT_TWARN   = 1;
	localparam int FAULT_BITS   = 12;
	localparam int MASK_BITS    = 13;
	localparam int CFG_SOFT_A   = 0;
	localparam int CFG_SOFT_B   = 1;
	localparam int CFG_SOFT_ON  = 4;

	// Identifier low nibble is arbitrary
	localparam logic [15:0] IDENT_VALUE = 16'h0010;
	localparam logic [15:0] MASK_RESET  = 16'h0EF1;
	localparam logic [15:0] CFG_RESET   = 16'h0D98;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_SLEEP   = 3'h0,
		MODE_POWERUP = 3'h1,
		MODE_NORMAL  = 3'h3,
		MODE_FAULT   = 3'h2,
		MODE_PDDELAY = 3'h6,
		MODE_PDWAIT  = 3'h7
	} mode_t;

endpackage

// File: hdl/sync2.sv
// Two-stage synchroniser for a group of asynchronous levels
module sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule

// File: sim/bridge_chk_assertions.sv
// Port assertions for the bridge control block
module bridge_chk (
	// Clock and reset
	input wire logic                              ref_clk,
	input wire logic                              reset_n,
	// Watched ports
	input wire logic                              select_n,
	input wire logic                              serial_out_en,
	input wire logic                              wake_input,
	input wire logic                              output_inhibit_input,
	input wire logic                              thermal_warning_level,
	input wire logic [bridge_pkg::FAULT_BITS-1:0] fault_live,
	input wire logic                              fault_flag_n,
	input wire logic                              bridge_output_en,
	input wire logic                              current_limit_half
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam int UP_MIN = 250;
	localparam int PD_MIN = 2000;
	logic        wake_q_r, wake_q_nxt;
	logic [11:0] dn_r, dn_nxt;
	logic [9:0]  up_r, up_nxt;

	// ------
	// Cycles since the wake pin last moved
	// ------
	always_comb begin
		wake_q_nxt = wake_input;
		dn_nxt = dn_r;
		up_nxt = up_r;
		if (wake_input)
			dn_nxt = 12'h000;
		else if (wake_q_r || dn_r != 12'h000)
			dn_nxt = (dn_r == 12'hFFF) ? dn_r : dn_r + 12'h001;
		if (!wake_input)
			up_nxt = 10'h000;
		else if (!wake_q_r || up_r != 10'h000)
			up_nxt = (up_r == 10'h3FF) ? up_r : up_r + 10'h001;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_q_r <= 1'b0;
			dn_r <= 12'h000;
			up_r <= 10'h000;
		end else begin
			wake_q_r <= wake_q_nxt;
			dn_r <= dn_nxt;
			up_r <= up_nxt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_miso_idle: assert property (select_n [*5] |-> !serial_out_en)
		else $error("data output driven while deselected");
	a_wake_drop: assert property ($fell(wake_input) |-> ##[1:6] (!fault_flag_n && !bridge_output_en))
		else $error("wake low did not stop outputs");
	a_pd_delay: assert property ((dn_r > 12'h006 && dn_r < PD_MIN) |-> !fault_flag_n)
		else $error("flag released inside power-down delay");
	a_pd_inhibit: assert property (($rose(fault_flag_n) && !wake_input) |-> !output_inhibit_input)
		else $error("flag released with inhibit high");
	a_pu_min: assert property (($rose(fault_flag_n) && up_r != 10'h000) |-> up_r >= UP_MIN)
		else $error("power-up flag pulse too short");
	a_inhibit_off: assert property (output_inhibit_input [*5] |-> !bridge_output_en)
		else $error("outputs driven while inhibited");
	a_half_limit: assert property ($rose(thermal_warning_level) |-> ##[1:3] current_limit_half)
		else $error("limit not halved on warning");
	a_fault_trip: assert property ((fault_flag_n && wake_input && $rose(fault_live[0])) |-> ##[1:3] !fault_flag_n)
		else $error("fault did not pull flag low");
	a_flag_off: assert property (!fault_flag_n [*4] |-> !bridge_output_en)
		else $error("outputs driven while flag low");
endmodule

bind bridge_ctrl bridge_chk i_chk (.ref_clk, .reset_n, .select_n, .serial_out_en, .wake_input,
	.output_inhibit_input, .thermal_warning_level, .fault_live, .fault_flag_n,
	.bridge_output_en, .current_limit_half);

// File: sim/spi_host.sv
// Serial master model standing in for the host controller
module spi_host (
	// Serial pins
	output logic      serial_clk,
	output logic      select_n,
	output logic      serial_in,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		serial_clk = 1'b0;
		select_n = 1'b1;
		serial_in = 1'b0;
	end

	// Clock idles low and only runs inside a frame; 48 ns period
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h00000000;
		select_n = 1'b0;
		#48;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = tx[i];
			#16 serial_clk = 1'b1;
			#24 serial_clk = 1'b0;
			rx[i] = miso;
			#8;
		end
		#32 select_n = 1'b1;
		serial_in = ~serial_in;
		#300;
	endtask
endmodule

// File: sim/bridge_driver_spi_and_modes_tb_top.sv
// Self-checking bench for the bridge control block
module bridge_driver_spi_and_modes_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic        ref_clk, reset_n, serial_clk, select_n, serial_in, serial_out, serial_out_en;
	logic        wake_input, output_inhibit_input, bridge_control_a, bridge_control_b;
	logic        supply_good, pump_low_threshold, thermal_warning_level, supplies_off, miso;
	logic        fault_flag_n, bridge_output_a, bridge_output_b, bridge_output_en;
	logic        current_limit_half, regulator_on, standby;
	logic [11:0] fault_live;
	logic [1:0]  psel;
	logic [15:0] cfg_e, stat_e, dd;
	logic [31:0] rx, eo;
	int          n_mismatch = 0, cmp_count = 0, cyc = 0;
	int          bad[3] = '{0, 15, 17};

	bridge_ctrl i_dut (
		.ref_clk, .reset_n, .serial_clk, .select_n, .serial_in, .serial_out, .serial_out_en,
		.wake_input, .output_inhibit_input, .bridge_control_a, .bridge_control_b,
		.supply_good, .pump_low_threshold, .fault_live, .thermal_warning_level, .supplies_off,
		.fault_flag_n, .bridge_output_a, .bridge_output_b, .bridge_output_en,
		.current_limit_half, .regulator_on, .standby
	);
	spi_host i_host (.serial_clk, .select_n, .serial_in, .miso);
	// Released line shows the inverse of its last level
	assign miso = serial_out_en ? serial_out : ~serial_out;

	always #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ------
	// Helpers
	// ------
	task automatic stop_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wait_flag(input logic v, input int lim, output int c);
		c = 0;
		while (fault_flag_n !== v && c < lim) begin
			@(negedge ref_clk);
			c++;
		end
	endtask

	function automatic logic [15:0] reply(input logic [1:0] s);
		case (s)
			bridge_pkg::SEL_IDENT:  return bridge_pkg::IDENT_VALUE;
			bridge_pkg::SEL_STATUS: return {4'h2, stat_e[11:0]};
			bridge_pkg::SEL_MASK:   return {3'h2, bridge_pkg::MASK_RESET[12:0]};
			default:                return {3'h3, cfg_e[12:0]};
		endcase
	endfunction

	// One 16-bit frame; reply must be the register picked by the last good frame
	task automatic cmd(input logic [15:0] c);
		logic [15:0] e;
		e = reply(psel);
		i_host.xfer({16'h0000, c}, 16, rx);
		chk({16'h0000, rx[15:0]}, {16'h0000, e});
		if (c[15] && c[14:13] == bridge_pkg::SEL_IDENT)
			stat_e[11] = 1'b1;
		else begin
			psel = c[14:13];
			if (c[15] && psel == bridge_pkg::SEL_CONFIG)
				cfg_e[12:0] = c[12:0];
			if (c[15] && psel == bridge_pkg::SEL_STATUS)
				stat_e[11:0] = stat_e[11:0] & ~c[11:0];
		end
	endtask

	task automatic wake_up();
		int c, d;
		tick(1);
		wake_input = 1'b1;
		wait_flag(1'b0, 10, c);
		wait_flag(1'b1, 600, d);
		chk(32'(c + d >= bridge_pkg::POWERUP_FLAG_CYC && c + d <= 510), 32'h1);
		chk({31'h0, regulator_on}, 32'h1);
		psel = bridge_pkg::SEL_STATUS;
		stat_e = 16'h0000;
		cfg_e = bridge_pkg::CFG_RESET;
		$display("test wake done");
	endtask

	task automatic sleep_down(input logic inh);
		int c, d;
		tick(1);
		output_inhibit_input = inh;
		supplies_off = !inh;
		wake_input = 1'b0;
		tick(6);
		chk({30'h0, fault_flag_n, bridge_output_en}, 32'h0);
		wait_flag(1'b1, 2800, c);
		if (inh) begin
			chk({31'h0, fault_flag_n}, 32'h0);
			output_inhibit_input = 1'b0;
			wait_flag(1'b1, 10, d);
			chk({31'h0, fault_flag_n}, 32'h0);
			supplies_off = 1'b1;
			wait_flag(1'b1, 10, d);
			chk({31'h0, fault_flag_n}, 32'h1);
		end else
			chk(32'(c + 6 >= 2000 && c + 6 <= 2760), 32'h1);
		$display("test sleep done");
	endtask

	// ------
	// Main sequence
	// ------
	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		{wake_input, output_inhibit_input, bridge_control_a, bridge_control_b} = 4'h0;
		{supply_good, pump_low_threshold, thermal_warning_level, supplies_off} = 4'h9;
		fault_live = 12'h000;
		void'($urandom(74225));
		tick(3);
		reset_n = 1'b1;
		tick(4);
		fork
			i_host.xfer(32'h00002000, 16, rx);
			begin
				tick(60);
				chk({30'h0, serial_out_en, regulator_on}, 32'h0);
			end
		join
		wake_up();
		cmd(16'h6000);
		cmd(16'h4000);
		cmd(16'h2000);
		cmd(16'h0000);
		cmd(16'hE000 | 16'(($urandom & 32'h1FFF) | 32'h10));
		repeat (4)
			cmd({1'b0, 2'($urandom), 13'($urandom)});
		cmd(16'h6000);
		$display("test registers done");
		tick(1);
		repeat (8) begin
			{output_inhibit_input, bridge_control_a, bridge_control_b} = 3'($urandom);
			tick(6);
			eo = {28'h0, output_inhibit_input, ~output_inhibit_input, 2'h0};
			eo[1] = eo[2] & (bridge_control_a ^ cfg_e[0]);
			eo[0] = eo[2] & (bridge_control_b ^ cfg_e[1]);
			chk({28'h0, standby, bridge_output_en, bridge_output_a & bridge_output_en,
				bridge_output_b & bridge_output_en}, eo);
		end
		output_inhibit_input = 1'b0;
		$display("test outputs done");
		foreach (bad[i]) begin
			i_host.xfer(32'($urandom), bad[i], rx);
			stat_e[11] = 1'b1;
			cmd(16'h2000);
			cmd(16'h2000);
			cmd(16'hA800);
		end
		cmd(16'h8000);
		cmd(16'h2000);
		cmd(16'hA800);
		$display("test framing done");
		dd = 16'($urandom);
		eo = {reply(psel), dd};
		i_host.xfer({dd, 16'h2000}, 32, rx);
		chk(rx, eo);
		psel = bridge_pkg::SEL_STATUS;
		$display("test chain done");
		tick(1);
		thermal_warning_level = 1'b1;
		tick(4);
		chk({31'h0, current_limit_half}, 32'h1);
		thermal_warning_level = 1'b0;
		fault_live = 12'h001;
		tick(4);
		chk({30'h0, fault_flag_n, bridge_output_en}, 32'h0);
		fault_live = 12'h000;
		tick(20);
		chk({30'h0, fault_flag_n, bridge_output_en}, 32'h0);
		$display("test fault done");
		sleep_down(1'b1);
		wake_up();
		cmd(16'h4000);
		sleep_down(1'b0);
		stop_test();
	end
endmodule
